// ===== hw/speed_torque_limit_sel.sv
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module speed_torque_limit_sel (
  input  logic                                      hclk,
  input  logic                                      hresetn,
  input  logic                                      hsel,
  input  logic [31:0]                               haddr,
  input  logic [1:0]                                htrans,
  input  logic                                      hwrite,
  input  logic [2:0]                                hsize,
  input  logic [31:0]                               hwdata,
  input  logic                                      hready,
  output logic                                      hreadyout,
  output logic                                      hresp,
  output logic [31:0]                               hrdata,
  input  logic                                      speed_select_in0,
  input  logic                                      speed_select_in1,
  input  logic                                      torque_select_in0,
  input  logic                                      torque_select_in1,
  input  logic                                      speed_limit_apply_in,
  input  logic                                      torque_limit_apply_in,
  input  logic                                      motor_enable_in,
  input  logic signed [limit_sel_pkg::DATA_W-1:0]   speed_cmd_in,
  input  logic        [limit_sel_pkg::LIM_W-1:0]    analog_speed_limit_in,
  input  logic        [limit_sel_pkg::LIM_W-1:0]    analog_torque_limit_in,
  output logic signed [limit_sel_pkg::DATA_W-1:0]   speed_cmd_out,
  output logic        [limit_sel_pkg::LIM_W-1:0]    torque_limit_out,
  output logic                                      speed_limit_active,
  output logic                                      torque_limit_active
);

  localparam int unsigned LW = limit_sel_pkg::LIM_W;
  localparam int unsigned DW = limit_sel_pkg::DATA_W;

  // ==========================================================================
  // Preset selection
  function automatic logic [LW-1:0] pick_limit(input logic [1:0]    sel,
                                                input logic [LW-1:0] analog,
                                                input logic [LW-1:0] p1,
                                                input logic [LW-1:0] p2,
                                                input logic [LW-1:0] p3);
    logic [LW-1:0] r;
    r = analog;
    case (sel)
      limit_sel_pkg::SEL_P1: r = p1;
      limit_sel_pkg::SEL_P2: r = p2;
      limit_sel_pkg::SEL_P3: r = p3;
      default:               r = analog;
    endcase
    return r;
  endfunction

  // ==========================================================================
  // Register state
  limit_sel_pkg::limit_cfg_t    cfg_q;
  logic [LW-1:0]                max_speed_q;
  logic [LW-1:0]                pspd_q [1:3];
  logic [LW-1:0]                ptrq_q [1:3];
  logic [LW-1:0]                atrq_scale_q;
  logic [LW-1:0]                app_spd_q;
  logic [LW-1:0]                app_trq_q;
  limit_sel_pkg::limit_status_t status_q;
  logic signed [DW-1:0]         speed_out_q;
  logic                         wr_pend_q;
  logic [7:0]                   wr_addr_q;
  logic [31:0]                  hrdata_q;
  logic                         hreadyout_q;
  logic                         hresp_q;

  logic                         addr_ok;
  logic [1:0]                   spd_sel;
  logic [1:0]                   trq_sel;
  logic                         is_torque;
  logic                         spd_on;
  logic [LW-1:0]                spd_pick;
  logic [LW-1:0]                spd_mag;
  logic signed [DW:0]           cmd_ext;
  logic signed [DW:0]           lim_ext;
  logic signed [DW-1:0]         speed_d;
  logic                         clamped_d;
  logic                         trq_on;
  logic [LW-1:0]                trq_pick;
  logic [LW-1:0]                trq_val;
  logic [31:0]                  rd_word;

  // ==========================================================================
  // Bus slave
  // Every transfer finishes with no wait state, so the response is always OKAY.
  assign addr_ok = hsel && hready && htrans[limit_sel_pkg::HTRANS_ACT_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= haddr[limit_sel_pkg::DEC_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q        <= limit_sel_pkg::CTRL_RST;
      max_speed_q  <= limit_sel_pkg::MAX_SPD_RST;
      atrq_scale_q <= limit_sel_pkg::ATRQ_RST;
      for (int i = 1; i <= 3; i++) begin
        pspd_q[i] <= limit_sel_pkg::PRESET_RST;
        ptrq_q[i] <= limit_sel_pkg::PRESET_RST;
      end
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        limit_sel_pkg::OFS_CTRL:    cfg_q        <= limit_sel_pkg::limit_cfg_t'(
                                                      hwdata[limit_sel_pkg::CFG_W-1:0]);
        limit_sel_pkg::OFS_MAX_SPD: max_speed_q  <= hwdata[LW-1:0];
        limit_sel_pkg::OFS_PSPD1:   pspd_q[1]    <= hwdata[LW-1:0];
        limit_sel_pkg::OFS_PSPD2:   pspd_q[2]    <= hwdata[LW-1:0];
        limit_sel_pkg::OFS_PSPD3:   pspd_q[3]    <= hwdata[LW-1:0];
        limit_sel_pkg::OFS_PTRQ1:   ptrq_q[1]    <= hwdata[LW-1:0];
        limit_sel_pkg::OFS_PTRQ2:   ptrq_q[2]    <= hwdata[LW-1:0];
        limit_sel_pkg::OFS_PTRQ3:   ptrq_q[3]    <= hwdata[LW-1:0];
        limit_sel_pkg::OFS_ATRQ:    atrq_scale_q <= hwdata[LW-1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr[limit_sel_pkg::DEC_W-1:0])
      limit_sel_pkg::OFS_CTRL:    rd_word[limit_sel_pkg::CFG_W-1:0] = cfg_q;
      limit_sel_pkg::OFS_MAX_SPD: rd_word[LW-1:0] = max_speed_q;
      limit_sel_pkg::OFS_PSPD1:   rd_word[LW-1:0] = pspd_q[1];
      limit_sel_pkg::OFS_PSPD2:   rd_word[LW-1:0] = pspd_q[2];
      limit_sel_pkg::OFS_PSPD3:   rd_word[LW-1:0] = pspd_q[3];
      limit_sel_pkg::OFS_PTRQ1:   rd_word[LW-1:0] = ptrq_q[1];
      limit_sel_pkg::OFS_PTRQ2:   rd_word[LW-1:0] = ptrq_q[2];
      limit_sel_pkg::OFS_PTRQ3:   rd_word[LW-1:0] = ptrq_q[3];
      limit_sel_pkg::OFS_ATRQ:    rd_word[LW-1:0] = atrq_scale_q;
      limit_sel_pkg::OFS_STATUS:  rd_word[limit_sel_pkg::STAT_W-1:0] = status_q;
      limit_sel_pkg::OFS_APP_SPD: rd_word[LW-1:0] = app_spd_q;
      limit_sel_pkg::OFS_APP_TRQ: rd_word[LW-1:0] = app_trq_q;
      default:                    rd_word = 32'h0000_0000;
    endcase
  end

  // Read data is sampled in the address phase; upper address bits are not decoded.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q    <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      hrdata_q    <= (addr_ok && !hwrite) ? rd_word : 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;

  // ==========================================================================
  // Speed limit selection
  assign spd_sel   = {speed_select_in0, speed_select_in1};
  assign trq_sel   = {torque_select_in0, torque_select_in1};
  assign is_torque = (cfg_q.mode == limit_sel_pkg::MODE_TORQUE) ||
                     (cfg_q.mode == limit_sel_pkg::MODE_TORQUE_ZERO);

  always_comb begin
    spd_on   = is_torque && cfg_q.action &&
               (cfg_q.speed_en || speed_limit_apply_in);
    spd_pick = pick_limit(spd_sel, analog_speed_limit_in,
                          pspd_q[1], pspd_q[2], pspd_q[3]);
    spd_mag  = (spd_on && (spd_pick < max_speed_q)) ? spd_pick : max_speed_q;
    cmd_ext  = {speed_cmd_in[DW-1], speed_cmd_in};
    lim_ext  = {2'b00, spd_mag};
    // Clamping after the profile keeps the limit independent of command source.
    if (cmd_ext > lim_ext) begin
      speed_d   = {1'b0, spd_mag};
      clamped_d = 1'b1;
    end else if (cmd_ext < -lim_ext) begin
      speed_d   = DW'(-lim_ext);
      clamped_d = 1'b1;
    end else begin
      speed_d   = speed_cmd_in;
      clamped_d = 1'b0;
    end
  end

  // ==========================================================================
  // Torque limit selection
  always_comb begin
    trq_pick = pick_limit(trq_sel, analog_torque_limit_in,
                          ptrq_q[1], ptrq_q[2], ptrq_q[3]);
    if (is_torque) begin
      trq_on  = motor_enable_in;
      trq_val = trq_pick;
    end else if (!cfg_q.action) begin
      trq_on  = 1'b1;
      trq_val = atrq_scale_q;
    end else begin
      trq_on  = cfg_q.torque_en || torque_limit_apply_in;
      trq_val = trq_pick;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      speed_out_q <= '0;
      app_spd_q   <= limit_sel_pkg::MAX_SPD_RST;
      app_trq_q   <= limit_sel_pkg::TORQUE_FULL;
      status_q    <= '0;
    end else begin
      speed_out_q <= speed_d;
      app_spd_q   <= spd_mag;
      app_trq_q   <= trq_on ? trq_val : limit_sel_pkg::TORQUE_FULL;
      status_q    <= '{torque_mode: is_torque, speed_clamped: clamped_d,
                       torque_active: trq_on, speed_active: spd_on};
    end
  end

  assign speed_cmd_out       = speed_out_q;
  assign torque_limit_out    = app_trq_q;
  assign speed_limit_active  = status_q.speed_active;
  assign torque_limit_active = status_q.torque_active;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_clamp_both_ways;
    ##1 ($signed(speed_out_q) <= $signed({1'b0, $past(max_speed_q)})) &&
        ($signed(speed_out_q) >= -$signed({1'b0, $past(max_speed_q)}));
  endproperty
  a_clamp_both_ways: assert property (p_clamp_both_ways)
    else $error("Speed output exceeds the maximum speed.");

  property p_preset_torque_only;
    !is_torque |=> !status_q.speed_active && (app_spd_q == $past(max_speed_q));
  endproperty
  a_preset_torque_only: assert property (p_preset_torque_only)
    else $error("Preset speed limit active outside torque mode.");

  property p_action_gates_speed;
    !cfg_q.action |=> !status_q.speed_active;
  endproperty
  a_action_gates_speed: assert property (p_action_gates_speed)
    else $error("Speed limit active with limit action off.");

  property p_speed_one_time;
    is_torque && cfg_q.action && cfg_q.speed_en |=>
      status_q.speed_active && (app_spd_q <= $past(spd_pick));
  endproperty
  a_speed_one_time: assert property (p_speed_one_time)
    else $error("Permanent speed limit not applied.");

  property p_speed_apply_input;
    is_torque && cfg_q.action && !cfg_q.speed_en |=>
      status_q.speed_active == $past(speed_limit_apply_in);
  endproperty
  a_speed_apply_input: assert property (p_speed_apply_input)
    else $error("Speed limit does not follow its apply input.");

  property p_max_under_preset;
    status_q.speed_active |-> app_spd_q <= $past(max_speed_q);
  endproperty
  a_max_under_preset: assert property (p_max_under_preset)
    else $error("Preset speed limit above the maximum speed.");

  property p_torque_one_time;
    !is_torque && cfg_q.action && cfg_q.torque_en |=>
      status_q.torque_active && (app_trq_q == $past(trq_pick));
  endproperty
  a_torque_one_time: assert property (p_torque_one_time)
    else $error("Permanent torque limit not applied.");

  property p_torque_apply_off;
    !is_torque && cfg_q.action && !cfg_q.torque_en && !torque_limit_apply_in |=>
      !status_q.torque_active && (app_trq_q == limit_sel_pkg::TORQUE_FULL);
  endproperty
  a_torque_apply_off: assert property (p_torque_apply_off)
    else $error("Torque limit applied without its apply input.");

  property p_torque_mode_enabled;
    is_torque |=> status_q.torque_active == $past(motor_enable_in);
  endproperty
  a_torque_mode_enabled: assert property (p_torque_mode_enabled)
    else $error("Torque mode limit does not follow motor enable.");

  property p_select_change;
    is_torque && motor_enable_in && (trq_sel != $past(trq_sel)) |=>
      app_trq_q == $past(trq_pick);
  endproperty
  a_select_change: assert property (p_select_change)
    else $error("Torque limit did not follow a select change.");

  property p_select_decode;
    is_torque && motor_enable_in && (trq_sel == limit_sel_pkg::SEL_P3) |=>
      app_trq_q == $past(ptrq_q[3]);
  endproperty
  a_select_decode: assert property (p_select_decode)
    else $error("Torque select code three did not pick preset three.");

  property p_analog_scale;
    !is_torque && !cfg_q.action |=> app_trq_q == $past(atrq_scale_q);
  endproperty
  a_analog_scale: assert property (p_analog_scale)
    else $error("Torque limit not taken from the analog scale.");

  property p_speed_analog_code;
    is_torque && cfg_q.action && cfg_q.speed_en && (spd_sel == limit_sel_pkg::SEL_ANALOG) &&
      (analog_speed_limit_in < max_speed_q) |=> app_spd_q == $past(analog_speed_limit_in);
  endproperty
  a_speed_analog_code: assert property (p_speed_analog_code)
    else $error("Speed select code zero did not pick the analog limit.");

  property p_clamp_exact_positive;
    !is_torque && !speed_cmd_in[DW-1] && (speed_cmd_in[DW-2:0] > max_speed_q) |=>
      speed_out_q == {1'b0, $past(max_speed_q)};
  endproperty
  a_clamp_exact_positive: assert property (p_clamp_exact_positive)
    else $error("Fast command not clamped to the maximum speed.");

  property p_clamp_pass_through;
    !is_torque && !speed_cmd_in[DW-1] && (speed_cmd_in[DW-2:0] <= max_speed_q) |=>
      speed_out_q == $past(speed_cmd_in);
  endproperty
  a_clamp_pass_through: assert property (p_clamp_pass_through)
    else $error("Command inside the maximum speed was altered.");

  property p_torque_inactive_full;
    !status_q.torque_active |-> app_trq_q == limit_sel_pkg::TORQUE_FULL;
  endproperty
  a_torque_inactive_full: assert property (p_torque_inactive_full)
    else $error("Torque limit applied while no torque limit is active.");

  property p_speed_preset_two;
    is_torque && cfg_q.action && cfg_q.speed_en && (spd_sel == limit_sel_pkg::SEL_P2) &&
      (pspd_q[2] < max_speed_q) |=> app_spd_q == $past(pspd_q[2]);
  endproperty
  a_speed_preset_two: assert property (p_speed_preset_two)
    else $error("Speed select code two did not pick preset two.");

  c_speed_clamped: cover property (status_q.speed_active && status_q.speed_clamped);
  c_torque_preset: cover property (status_q.torque_active && !status_q.torque_mode);
  c_torque_mode_switch: cover property (is_torque && motor_enable_in ##1
                                        trq_sel != $past(trq_sel));
  c_torque_released: cover property (status_q.torque_active ##1 !status_q.torque_active);

endmodule

// ===== hw/limit_sel_pkg.sv
// Overview of operation
// - Clamp speed both ways to the maximum speed in every mode and source.
// - Preset speed limit acts only in torque mode; otherwise only the clamp.
// - Limit-action set to one enables the speed limit function.
// - Speed enable field set: limit always on, preset chosen by speed selects.
// - Speed enable field clear: limit on only while speed apply input is on.
// - The maximum speed clamp still holds while a preset speed limit acts.
// - Position or speed mode, torque enable set: limit always on, by torque selects.
// - Torque enable field clear: limit on only while torque apply input is on.
// - Torque mode keeps a torque limit while the motor is enabled.
// - Torque mode follows torque select changes at once, no trigger needed.
// - Torque selects: 00 analog, 01/10/11 presets 1 to 3; first input is MSB.
// - Position or speed mode, limit-action zero: torque limited by the analog maximum torque scale value.
package limit_sel_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned DATA_W = 16;
  localparam int unsigned LIM_W  = 15;
  localparam int unsigned DEC_W  = 8;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_MAX_SPD = 8'h04;
  localparam logic [7:0] OFS_PSPD1   = 8'h08;
  localparam logic [7:0] OFS_PSPD2   = 8'h0c;
  localparam logic [7:0] OFS_PSPD3   = 8'h10;
  localparam logic [7:0] OFS_PTRQ1   = 8'h14;
  localparam logic [7:0] OFS_PTRQ2   = 8'h18;
  localparam logic [7:0] OFS_PTRQ3   = 8'h1c;
  localparam logic [7:0] OFS_ATRQ    = 8'h20;
  localparam logic [7:0] OFS_STATUS  = 8'h24;
  localparam logic [7:0] OFS_APP_SPD = 8'h28;
  localparam logic [7:0] OFS_APP_TRQ = 8'h2c;

  // ==========================================================================
  // Reset values
  localparam logic [14:0] MAX_SPD_RST = 15'h7fff;
  localparam logic [14:0] PRESET_RST  = 15'h0000;
  localparam logic [14:0] ATRQ_RST    = 15'h0064;
  localparam logic [14:0] TORQUE_FULL = 15'h7fff;

  // ==========================================================================
  // Select codes
  localparam logic [1:0] SEL_ANALOG = 2'b00;
  localparam logic [1:0] SEL_P1     = 2'b01;
  localparam logic [1:0] SEL_P2     = 2'b10;
  localparam logic [1:0] SEL_P3     = 2'b11;

  // ==========================================================================
  // AHB constants
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam int unsigned HTRANS_ACT_BIT = 1;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    MODE_PULSE_POSITION    = 3'b000,
    MODE_INTERNAL_POSITION = 3'b001,
    MODE_SPEED             = 3'b010,
    MODE_SPEED_ZERO        = 3'b011,
    MODE_TORQUE            = 3'b100,
    MODE_TORQUE_ZERO       = 3'b101
  } op_mode_t;

  typedef struct packed {
    logic     action;
    logic     torque_en;
    logic     speed_en;
    op_mode_t mode;
  } limit_cfg_t;

  typedef struct packed {
    logic torque_mode;
    logic speed_clamped;
    logic torque_active;
    logic speed_active;
  } limit_status_t;

  localparam int unsigned CFG_W  = $bits(limit_cfg_t);
  localparam int unsigned STAT_W = $bits(limit_status_t);
  localparam limit_cfg_t CTRL_RST = '{action: 1'b0, torque_en: 1'b0, speed_en: 1'b0,
                                      mode: MODE_PULSE_POSITION};

endpackage

// ===== sim/machine_ctrl_model.sv
`timescale 1ns/1ps
// ============================================================================
// Machine controller contacts
// Contacts change only on a clock edge, so a select pair never shows a mixed code.
module machine_ctrl_model (
  input  logic       hclk,
  input  logic       hresetn,
  input  logic [1:0] req_spd_sel,
  input  logic [1:0] req_trq_sel,
  input  logic       req_spd_apply,
  input  logic       req_trq_apply,
  input  logic       req_enable,
  output logic       speed_select_in0,
  output logic       speed_select_in1,
  output logic       torque_select_in0,
  output logic       torque_select_in1,
  output logic       speed_limit_apply_in,
  output logic       torque_limit_apply_in,
  output logic       motor_enable_in
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {speed_select_in0, speed_select_in1, torque_select_in0, torque_select_in1} <= 4'h0;
      {speed_limit_apply_in, torque_limit_apply_in, motor_enable_in} <= 3'h0;
    end else begin
      {speed_select_in0, speed_select_in1}   <= req_spd_sel;
      {torque_select_in0, torque_select_in1} <= req_trq_sel;
      speed_limit_apply_in  <= req_spd_apply;
      torque_limit_apply_in <= req_trq_apply;
      motor_enable_in       <= req_enable;
    end
  end
endmodule

// ===== sim/servo_speed_torque_limit_select_bench.sv
`timescale 1ns/1ps
// ============================================================================
// Bench
module servo_speed_torque_limit_select_bench;
  logic               hclk = 1'b0;
  logic               hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        [31:0] haddr, hwdata, hrdata;
  logic        [1:0]  htrans, r_ss, r_ts;
  logic               r_aps, r_apt, r_en, s0, s1, t0, t1, aps, apt, en, sla, tla;
  logic signed [15:0] cmd_in, speed_cmd_out;
  logic        [14:0] a_spd, a_trq, torque_limit_out, max_spd, atrq;
  logic        [14:0] pspd [1:3];
  logic        [14:0] ptrq [1:3];
  logic        [5:0]  ctrl;
  int                 n_errors = 0;
  int                 n_compared = 0;
  assign hready = hreadyout;
  always #50 hclk = ~hclk;

  speed_torque_limit_sel i_speed_torque_limit_sel (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .speed_select_in0(s0), .speed_select_in1(s1),
    .torque_select_in0(t0), .torque_select_in1(t1), .speed_limit_apply_in(aps),
    .torque_limit_apply_in(apt), .motor_enable_in(en), .speed_cmd_in(cmd_in),
    .analog_speed_limit_in(a_spd), .analog_torque_limit_in(a_trq),
    .speed_cmd_out(speed_cmd_out), .torque_limit_out(torque_limit_out),
    .speed_limit_active(sla), .torque_limit_active(tla));
  machine_ctrl_model i_machine_ctrl_model (.hclk(hclk), .hresetn(hresetn),
    .req_spd_sel(r_ss), .req_trq_sel(r_ts), .req_spd_apply(r_aps), .req_trq_apply(r_apt),
    .req_enable(r_en), .speed_select_in0(s0), .speed_select_in1(s1),
    .torque_select_in0(t0), .torque_select_in1(t1), .speed_limit_apply_in(aps),
    .torque_limit_apply_in(apt), .motor_enable_in(en));

  // ==========================================================================
  // Shared tasks
  task automatic complete_run();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_ready();
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge hclk);
      if (hready === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      complete_run();
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= limit_sel_pkg::HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_ready();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    check(hresp, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    ahb(1'b1, a, d, v);
    case (a)
      limit_sel_pkg::OFS_CTRL:    ctrl = d[5:0];
      limit_sel_pkg::OFS_MAX_SPD: max_spd = d[14:0];
      limit_sel_pkg::OFS_PSPD1:   pspd[1] = d[14:0];
      limit_sel_pkg::OFS_PSPD2:   pspd[2] = d[14:0];
      limit_sel_pkg::OFS_PSPD3:   pspd[3] = d[14:0];
      limit_sel_pkg::OFS_PTRQ1:   ptrq[1] = d[14:0];
      limit_sel_pkg::OFS_PTRQ2:   ptrq[2] = d[14:0];
      limit_sel_pkg::OFS_PTRQ3:   ptrq[3] = d[14:0];
      limit_sel_pkg::OFS_ATRQ:    atrq = d[14:0];
      default: ;
    endcase
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    check(v, exp);
  endtask
  task automatic cfg(input logic act, ten, sen, input logic [2:0] m);
    wr(limit_sel_pkg::OFS_CTRL, {26'h0, act, ten, sen, m});
  endtask
  // Drives contacts and command, then compares after the two-edge path has settled.
  task automatic drive_chk(input logic [1:0] ss, ts, input logic ap_s, ap_t, e,
                           input logic signed [15:0] c);
    logic [14:0] sp, tp, lim, tx;
    logic        tm, sa, ta;
    logic signed [15:0] ls, sx;
    r_ss <= ss;
    r_ts <= ts;
    r_aps <= ap_s;
    r_apt <= ap_t;
    r_en <= e;
    cmd_in <= c;
    tm = (ctrl[2:0] == 3'h4) || (ctrl[2:0] == 3'h5);
    sp = (ss == 2'b00) ? a_spd : pspd[ss];
    tp = (ts == 2'b00) ? a_trq : ptrq[ts];
    sa = tm && ctrl[5] && (ctrl[3] || ap_s);
    lim = (sa && sp < max_spd) ? sp : max_spd;
    if (tm) begin
      ta = e;
      tx = tp;
    end else if (!ctrl[5]) begin
      ta = 1'b1;
      tx = atrq;
    end else begin
      ta = ctrl[4] || ap_t;
      tx = tp;
    end
    if (!ta) tx = limit_sel_pkg::TORQUE_FULL;
    ls = {1'b0, lim};
    sx = (c > ls) ? ls : (c < -ls) ? -ls : c;
    repeat (3) @(posedge hclk);
    check(speed_cmd_out, sx);
    check(sla, sa);
    check(tla, ta);
    check(torque_limit_out, tx);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    rd_chk(limit_sel_pkg::OFS_CTRL, 32'h0);
    rd_chk(limit_sel_pkg::OFS_MAX_SPD, 32'h7fff);
    rd_chk(limit_sel_pkg::OFS_PSPD3, 32'h0);
    rd_chk(limit_sel_pkg::OFS_ATRQ, 32'h64);
    wr(8'h40, 32'h1234);
    rd_chk(8'h40, 32'h0);
    wr(limit_sel_pkg::OFS_MAX_SPD, 32'h3e8);
    wr(limit_sel_pkg::OFS_PSPD1, 32'h64);
    wr(limit_sel_pkg::OFS_PSPD2, 32'hc8);
    wr(limit_sel_pkg::OFS_PSPD3, 32'h7d0);
    wr(limit_sel_pkg::OFS_PTRQ1, 32'h11);
    wr(limit_sel_pkg::OFS_PTRQ2, 32'h22);
    wr(limit_sel_pkg::OFS_PTRQ3, 32'h33);
    wr(limit_sel_pkg::OFS_ATRQ, 32'h50);
    rd_chk(limit_sel_pkg::OFS_PSPD2, 32'hc8);
  endtask
  task automatic t_pos_modes();
    for (int m = 0; m < 8; m++) begin
      if (m == 4 || m == 5) continue;
      cfg(1'b0, 1'b0, 1'b1, 3'(m));
      drive_chk(2'b01, 2'b10, 1'b1, 1'b0, 1'b1, 16'sd1500);
      drive_chk(2'b01, 2'b10, 1'b1, 1'b0, 1'b1, -16'sd1500);
    end
    cfg(1'b1, 1'b0, 1'b0, 3'h2);
    drive_chk(2'b00, 2'b11, 1'b0, 1'b0, 1'b1, 16'sd500);
    for (int t = 0; t < 4; t++) drive_chk(2'b00, 2'(t), 1'b0, 1'b1, 1'b0, 16'sd0);
    cfg(1'b1, 1'b1, 1'b0, 3'h1);
    drive_chk(2'b00, 2'b10, 1'b0, 1'b0, 1'b0, 16'sd0);
  endtask
  task automatic t_torque_mode();
    cfg(1'b0, 1'b0, 1'b0, 3'h4);
    drive_chk(2'b00, 2'b11, 1'b0, 1'b0, 1'b0, 16'sd0);
    for (int t = 3; t >= 0; t--) drive_chk(2'b00, 2'(t), 1'b0, 1'b0, 1'b1, 16'sd0);
    cfg(1'b1, 1'b0, 1'b0, 3'h5);
    for (int s = 0; s < 4; s++) begin
      drive_chk(2'(s), 2'b01, 1'b0, 1'b0, 1'b1, 16'sd1500);
      drive_chk(2'(s), 2'b01, 1'b1, 1'b0, 1'b1, 16'sd1500);
      drive_chk(2'(s), 2'b01, 1'b1, 1'b0, 1'b1, -16'sd1500);
    end
    cfg(1'b1, 1'b0, 1'b1, 3'h4);
    drive_chk(2'b10, 2'b00, 1'b0, 1'b0, 1'b1, 16'sd300);
    drive_chk(2'b00, 2'b00, 1'b0, 1'b0, 1'b1, 16'sd600);
    cfg(1'b0, 1'b0, 1'b1, 3'h4);
    drive_chk(2'b10, 2'b00, 1'b1, 1'b0, 1'b1, 16'sd300);
    rd_chk(limit_sel_pkg::OFS_STATUS, 32'h0000_000a);
    rd_chk(limit_sel_pkg::OFS_APP_SPD, {17'h0, max_spd});
    rd_chk(limit_sel_pkg::OFS_APP_TRQ, {17'h0, a_trq});
  endtask

  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {r_ss, r_ts, r_aps, r_apt, r_en} = '0;
    cmd_in = 16'sd0;
    a_spd = 15'h0190;
    a_trq = 15'h0044;
    ctrl = 6'h00;
    max_spd = limit_sel_pkg::MAX_SPD_RST;
    atrq = limit_sel_pkg::ATRQ_RST;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_pos_modes();
    t_torque_mode();
    complete_run();
  end
endmodule
